// ---- include/ptb_pkg.sv ----
// Shared constants for the PWM timer buffer-transfer block
package ptb_pkg;
	localparam int DW = 16;
	localparam int AW = 5;
	// Register offsets (word index on the plain register port)
	localparam logic [4:0] OFS_CNT = 5'h00;
	localparam logic [4:0] OFS_CCA = 5'h01;
	localparam logic [4:0] OFS_CCB = 5'h02;
	localparam logic [4:0] OFS_CCC = 5'h03;
	localparam logic [4:0] OFS_CCD = 5'h04;
	localparam logic [4:0] OFS_CCE = 5'h05;
	localparam logic [4:0] OFS_CCF = 5'h06;
	localparam logic [4:0] OFS_PER = 5'h07;
	localparam logic [4:0] OFS_PBUF = 5'h08;
	localparam logic [4:0] OFS_PDBUF = 5'h09;
	localparam logic [4:0] OFS_ADA = 5'h0A;
	localparam logic [4:0] OFS_ADB = 5'h0B;
	localparam logic [4:0] OFS_ADBA = 5'h0C;
	localparam logic [4:0] OFS_ADBB = 5'h0D;
	localparam logic [4:0] OFS_ADDA = 5'h0E;
	localparam logic [4:0] OFS_ADDB = 5'h0F;
	localparam logic [4:0] OFS_DTU = 5'h10;
	localparam logic [4:0] OFS_DTD = 5'h11;
	localparam logic [4:0] OFS_DBU = 5'h12;
	localparam logic [4:0] OFS_DBD = 5'h13;
	localparam logic [4:0] OFS_CTRL = 5'h14;
	localparam logic [4:0] OFS_STAT = 5'h15;
	localparam logic [4:0] OFS_CCBA = 5'h16;
	localparam logic [4:0] OFS_CCBB = 5'h17;
	localparam logic [4:0] OFS_CCDA = 5'h18;
	localparam logic [4:0] OFS_CCDB = 5'h19;
	// Control register fields
	localparam int CTRL_MODE_A = 0;
	localparam int CTRL_MODE_B = 2;
	localparam int CTRL_MODE_P = 4;
	localparam int CTRL_TIM_A = 6;
	localparam int CTRL_TIM_B = 8;
	localparam int CTRL_DBL_A = 10;
	localparam int CTRL_DBL_B = 11;
	localparam int CTRL_TRI = 12;
	localparam int CTRL_RUN = 13;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	// Buffer modes for compare-capture and period
	typedef enum logic [1:0] {
		PTB_BUF_NONE = 2'b00,
		PTB_BUF_SINGLE = 2'b01,
		PTB_BUF_DOUBLE = 2'b10
	} ptb_buf_t;
	// Transfer timing for the A/D trigger buffers
	typedef enum logic [1:0] {
		PTB_TRANSFER_NEVER = 2'b00,
		PTB_TRANSFER_AT_PEAK = 2'b01,
		PTB_TRANSFER_AT_VALLEY = 2'b10,
		PTB_TRANSFER_AT_PEAK_AND_VALLEY = 2'b11
	} ptb_tim_t;
endpackage

// ---- hdl/ptb_buf_chain.sv ----
`timescale 1ns/100ps
// Active register with buffer and double buffer, mode selected chain
module ptb_buf_chain
	import ptb_pkg::*;
#(
	parameter int W = 16
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Software writes
	input wire logic wr_act,
	input wire logic wr_buf,
	input wire logic wr_dbl,
	input wire logic [W-1:0] wdata,
	// Mode and transfer strobe
	input wire logic [1:0] mode,
	input wire logic xfer,
	// Stored values
	output logic [W-1:0] act_q,
	output logic [W-1:0] buf_q,
	output logic [W-1:0] dbl_q
);
	logic [W-1:0] act_r;
	logic [W-1:0] buf_r;
	logic [W-1:0] dbl_r;
	// Transfer only happens in a buffered mode
	wire logic do_buf = xfer && (mode == PTB_BUF_SINGLE || mode == PTB_BUF_DOUBLE);
	wire logic do_dbl = xfer && (mode == PTB_BUF_DOUBLE);

	// Transfer beats a same-cycle software write, so the chain never tears
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			act_r <= '0;
			buf_r <= '0;
			dbl_r <= '0;
		end
		else
		begin
			if (do_buf)
				act_r <= buf_r;
			else if (wr_act)
				act_r <= wdata;
			if (do_dbl)
				buf_r <= dbl_r;
			else if (wr_buf)
				buf_r <= wdata;
			if (wr_dbl)
				dbl_r <= wdata;
		end
	end

	assign act_q = act_r;
	assign buf_q = buf_r;
	assign dbl_q = dbl_r;
endmodule

// ---- hdl/ptb_xfer_sel.sv ----
`timescale 1ns/100ps
// Picks the A/D trigger buffer transfer moment from timing selection
module ptb_xfer_sel
	import ptb_pkg::*;
(
	// Selection
	input wire logic [1:0] timing,
	input wire logic tri_mode,
	// Count events
	input wire logic at_peak,
	input wire logic at_valley,
	input wire logic at_wrap,
	// Transfer strobe
	output logic xfer
);
	// Triangle: peak and/or valley; sawtooth: any enabled choice uses wrap
	wire logic tri_x = (timing[0] && at_peak) || (timing[1] && at_valley);
	wire logic saw_x = (timing != PTB_TRANSFER_NEVER) && at_wrap;
	assign xfer = tri_mode ? tri_x : saw_x;
endmodule

// ---- hdl/ptb_top.sv ----
`timescale 1ns/100ps
// Register access and buffer transfer of one PWM timer channel
module ptb_top
	import ptb_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [ptb_pkg::AW-1:0] addr,
	input wire logic [ptb_pkg::DW-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [ptb_pkg::DW-1:0] rdata,
	// Count events from the counting logic
	input wire logic at_peak,
	input wire logic at_valley,
	input wire logic at_wrap,
	input wire logic count_step,
	input wire logic count_down,
	// Status to the rest of the timer
	output logic running,
	output logic triangle_mode,
	output logic period_end,
	output logic [ptb_pkg::DW-1:0] timer_counter_value
);
	import ptb_pkg::*;

	logic [DW-1:0] ctrl_r; // Mode and run control
	logic [DW-1:0] cnt_r; // Counter value
	logic [DW-1:0] cc_r [2:5]; // Compare-capture C..F
	logic [DW-1:0] dt_r [0:3]; // Dead-time up, down, buffer up, buffer down
	logic [DW-1:0] rdata_r; // Registered read data
	logic [DW-1:0] rd_nxt;
	logic [DW-1:0] cca, ccba, ccda, ccb, ccbb, ccdb;
	logic [DW-1:0] per, pbuf, pdbuf;
	logic [DW-1:0] ada, adba, adda, adb, adbb, addb;
	logic xfer_a, xfer_b;
	logic err_r; // Sticky: refused write seen

	// Write decode
	function automatic logic hit(input logic [AW-1:0] a, input logic [4:0] o);
		hit = (a == o);
	endfunction

	wire logic tri_m = ctrl_r[CTRL_TRI];
	wire logic run = ctrl_r[CTRL_RUN];
	// Period end is the valley in triangle modes, the wrap otherwise
	wire logic pend = tri_m ? at_valley : at_wrap;
	// Mode changes refused while counting
	wire logic ctrl_ok = !run || (wdata[CTRL_RUN] && (wdata[CTRL_RUN-1:0] == ctrl_r[CTRL_RUN-1:0]));
	wire logic wr_ctrl = wr && hit(addr, OFS_CTRL) && ctrl_ok;
	wire logic wr_cnt = wr && hit(addr, OFS_CNT) && !run;
	wire logic refused = wr && ((hit(addr, OFS_CNT) && run) || (hit(addr, OFS_CTRL) && !ctrl_ok));
	// A/D mode: single unless double flag set
	wire logic [1:0] mode_ada = ctrl_r[CTRL_DBL_A] ? PTB_BUF_DOUBLE : PTB_BUF_SINGLE;
	wire logic [1:0] mode_adb = ctrl_r[CTRL_DBL_B] ? PTB_BUF_DOUBLE : PTB_BUF_SINGLE;

	// Control register: reset clears the buffer modes; A/D chains fall back to single buffering
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ctrl_r <= CTRL_RST;
		else if (wr_ctrl)
			ctrl_r <= wdata;
	end

	// Refused-write flag, set wins over status read clear
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			err_r <= 1'b0;
		else if (refused)
			err_r <= 1'b1;
		else if (rd && hit(addr, OFS_STAT))
			err_r <= 1'b0;
	end

	// Counter: software load when stopped, otherwise follows count steps
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_r <= '0;
		else if (wr_cnt)
			cnt_r <= wdata;
		else if (run && count_step)
			cnt_r <= count_down ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
	end

	// Plain compare-capture and dead-time registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 2; i <= 5; i++)
				cc_r[i] <= '0;
			for (int j = 0; j < 4; j++)
				dt_r[j] <= '0;
		end
		else if (wr)
		begin
			if (hit(addr, OFS_CCC)) cc_r[2] <= wdata;
			if (hit(addr, OFS_CCD)) cc_r[3] <= wdata;
			if (hit(addr, OFS_CCE)) cc_r[4] <= wdata;
			if (hit(addr, OFS_CCF)) cc_r[5] <= wdata;
			if (hit(addr, OFS_DTU)) dt_r[0] <= wdata;
			if (hit(addr, OFS_DTD)) dt_r[1] <= wdata;
			if (hit(addr, OFS_DBU)) dt_r[2] <= wdata;
			if (hit(addr, OFS_DBD)) dt_r[3] <= wdata;
		end
	end

	// Compare-capture A chain, transfers at period end
	ptb_buf_chain #(.W(DW)) u_cca (
		.clk(clk), .rst(rst),
		.wr_act(wr && hit(addr, OFS_CCA)), .wr_buf(wr && hit(addr, OFS_CCBA)),
		.wr_dbl(wr && hit(addr, OFS_CCDA)), .wdata(wdata),
		.mode(ctrl_r[CTRL_MODE_A+:2]), .xfer(run && pend),
		.act_q(cca), .buf_q(ccba), .dbl_q(ccda)
	);
	// Compare-capture B chain
	ptb_buf_chain #(.W(DW)) u_ccb (
		.clk(clk), .rst(rst),
		.wr_act(wr && hit(addr, OFS_CCB)), .wr_buf(wr && hit(addr, OFS_CCBB)),
		.wr_dbl(wr && hit(addr, OFS_CCDB)), .wdata(wdata),
		.mode(ctrl_r[CTRL_MODE_B+:2]), .xfer(run && pend),
		.act_q(ccb), .buf_q(ccbb), .dbl_q(ccdb)
	);
	// Period chain with its buffer and double buffer
	ptb_buf_chain #(.W(DW)) u_per (
		.clk(clk), .rst(rst),
		.wr_act(wr && hit(addr, OFS_PER)), .wr_buf(wr && hit(addr, OFS_PBUF)),
		.wr_dbl(wr && hit(addr, OFS_PDBUF)), .wdata(wdata),
		.mode(ctrl_r[CTRL_MODE_P+:2]), .xfer(run && pend),
		.act_q(per), .buf_q(pbuf), .dbl_q(pdbuf)
	);

	// A/D transfer moments
	ptb_xfer_sel u_sel_a (
		.timing(ctrl_r[CTRL_TIM_A+:2]), .tri_mode(tri_m),
		.at_peak(at_peak), .at_valley(at_valley), .at_wrap(at_wrap), .xfer(xfer_a)
	);
	ptb_xfer_sel u_sel_b (
		.timing(ctrl_r[CTRL_TIM_B+:2]), .tri_mode(tri_m),
		.at_peak(at_peak), .at_valley(at_valley), .at_wrap(at_wrap), .xfer(xfer_b)
	);
	// A/D trigger timing chains with double buffers
	ptb_buf_chain #(.W(DW)) u_ada (
		.clk(clk), .rst(rst),
		.wr_act(wr && hit(addr, OFS_ADA)), .wr_buf(wr && hit(addr, OFS_ADBA)),
		.wr_dbl(wr && hit(addr, OFS_ADDA)), .wdata(wdata),
		.mode(mode_ada), .xfer(run && xfer_a),
		.act_q(ada), .buf_q(adba), .dbl_q(adda)
	);
	ptb_buf_chain #(.W(DW)) u_adb (
		.clk(clk), .rst(rst),
		.wr_act(wr && hit(addr, OFS_ADB)), .wr_buf(wr && hit(addr, OFS_ADBB)),
		.wr_dbl(wr && hit(addr, OFS_ADDB)), .wdata(wdata),
		.mode(mode_adb), .xfer(run && xfer_b),
		.act_q(adb), .buf_q(adbb), .dbl_q(addb)
	);

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		rd_nxt = '0;
		case (addr)
			OFS_CNT: rd_nxt = cnt_r;
			OFS_CCA: rd_nxt = cca;
			OFS_CCB: rd_nxt = ccb;
			OFS_CCC: rd_nxt = cc_r[2];
			OFS_CCD: rd_nxt = cc_r[3];
			OFS_CCE: rd_nxt = cc_r[4];
			OFS_CCF: rd_nxt = cc_r[5];
			OFS_PER: rd_nxt = per;
			OFS_PBUF: rd_nxt = pbuf;
			OFS_PDBUF: rd_nxt = pdbuf;
			OFS_ADA: rd_nxt = ada;
			OFS_ADB: rd_nxt = adb;
			OFS_ADBA: rd_nxt = adba;
			OFS_ADBB: rd_nxt = adbb;
			OFS_ADDA: rd_nxt = adda;
			OFS_ADDB: rd_nxt = addb;
			OFS_DTU: rd_nxt = dt_r[0];
			OFS_DTD: rd_nxt = dt_r[1];
			OFS_DBU: rd_nxt = dt_r[2];
			OFS_DBD: rd_nxt = dt_r[3];
			OFS_CTRL: rd_nxt = ctrl_r;
			OFS_STAT: rd_nxt = {14'h0000, err_r, run};
			OFS_CCBA: rd_nxt = ccba;
			OFS_CCBB: rd_nxt = ccbb;
			OFS_CCDA: rd_nxt = ccda;
			OFS_CCDB: rd_nxt = ccdb;
			default: rd_nxt = '0;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata_r <= '0;
		else if (rd)
			rdata_r <= rd_nxt;
		else
			rdata_r <= '0;
	end

	assign rdata = rdata_r;
	assign running = run;
	assign triangle_mode = tri_m;
	assign period_end = run && pend;
	assign timer_counter_value = cnt_r;

	// Checks
	AST_CNT_LOCK: assert property (@(posedge clk) disable iff (rst)
		(run && $past(run)) && $past(wr && hit(addr, OFS_CNT)) && !$past(count_step) |-> $stable(cnt_r))
		else $error("counter changed by write while running");
	AST_MODE_LOCK: assert property (@(posedge clk) disable iff (rst)
		$past(run) && run |-> ctrl_r[CTRL_RUN-1:0] == $past(ctrl_r[CTRL_RUN-1:0]))
		else $error("buffer mode changed while running");
	AST_NOBUF_WR: assert property (@(posedge clk) disable iff (rst)
		wr && hit(addr, OFS_PER) && ctrl_r[CTRL_MODE_P+:2] == PTB_BUF_NONE |=> per == $past(wdata))
		else $error("unbuffered period write lost");
	AST_SGL_XFER: assert property (@(posedge clk) disable iff (rst)
		run && pend && ctrl_r[CTRL_MODE_A+:2] == PTB_BUF_SINGLE |=> cca == $past(ccba))
		else $error("single buffer transfer missed");
	AST_DBL_XFER: assert property (@(posedge clk) disable iff (rst)
		run && xfer_a && ctrl_r[CTRL_DBL_A] |=> adba == $past(adda) && ada == $past(adba))
		else $error("double buffer transfer missed");
	AST_SAW_WRAP: assert property (@(posedge clk) disable iff (rst)
		!tri_m && at_wrap && ctrl_r[CTRL_TIM_B+:2] != PTB_TRANSFER_NEVER |-> xfer_b)
		else $error("sawtooth wrap transfer missing");
	AST_TRI_PEAK: assert property (@(posedge clk) disable iff (rst)
		tri_m && at_peak && !at_valley |-> xfer_a == ctrl_r[CTRL_TIM_A])
		else $error("peak transfer selection wrong");
	AST_READ: assert property (@(posedge clk) disable iff (rst)
		rd && hit(addr, OFS_DTU) |=> rdata == $past(dt_r[0]))
		else $error("read data wrong");
	AST_RESET_MODE: assert property (@(posedge clk)
		$fell(rst) |-> ctrl_r == CTRL_RST)
		else $error("modes not cleared by reset");
	COV_SGL: cover property (@(posedge clk) disable iff (rst) run && pend && ctrl_r[CTRL_MODE_A+:2] == PTB_BUF_SINGLE);
	COV_DBL: cover property (@(posedge clk) disable iff (rst) run && xfer_a && ctrl_r[CTRL_DBL_A]);
	COV_TRI: cover property (@(posedge clk) disable iff (rst) run && tri_m && at_peak);
	COV_REF: cover property (@(posedge clk) disable iff (rst) refused);
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/100ps
// Self-checking bench for the PWM timer register and buffer-transfer block
module tb_top;
	import ptb_pkg::*;
	logic clk = 1'b0; // 50 MHz clock
	logic rst = 1'b1; // Async reset, active high
	logic [AW-1:0] addr = '0;
	logic [DW-1:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic at_peak = 1'b0;
	logic at_valley = 1'b0;
	logic at_wrap = 1'b0;
	logic [DW-1:0] rdata;
	logic running;
	logic triangle_mode;
	logic period_end;
	logic [DW-1:0] timer_counter_value;
	int failures = 0; // Mismatch count
	int num_checks = 0; // Comparison count
	// Half period of 10 ns
	always #10 clk = ~clk;
	// Counter stepping stays off so the counter value is predictable
	ptb_top u_ptb_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.at_peak(at_peak), .at_valley(at_valley), .at_wrap(at_wrap), .count_step(1'b0), .count_down(1'b0),
		.running(running), .triangle_mode(triangle_mode), .period_end(period_end),
		.timer_counter_value(timer_counter_value));
	// Compare one value, count it, report a mismatch at once
	task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Verdict and end of run
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Reset held for three cycles; a running timer can only be stopped this way
	task automatic do_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
	endtask
	// One-cycle write strobe
	task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// One-cycle read strobe, data judged in the following cycle only
	task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
	endtask
	// One-cycle count event: 0 peak, 1 valley, 2 wrap; period_end judged mid-pulse
	task automatic pulse(input int which, input logic pe_exp);
		@(posedge clk);
		at_peak <= (which == 0);
		at_valley <= (which == 1);
		at_wrap <= (which == 2);
		@(negedge clk);
		chk({15'h0000, period_end}, {15'h0000, pe_exp});
		@(posedge clk);
		{at_peak, at_valley, at_wrap} <= 3'b000;
	endtask
	// Reset values and plain read/write of the data registers at offsets 0 to 19
	task automatic t_regs;
		logic [AW-1:0] a;
		do_reset();
		rd_chk(OFS_CTRL, CTRL_RST);
		for (int i = 0; i <= 19; i++)
		begin
			a = i[AW-1:0];
			rd_chk(a, 16'h0000);
			wr_reg(a, 16'hA500 ^ (16'h0F0F * i[15:0]));
		end
		for (int i = 0; i <= 19; i++)
		begin
			a = i[AW-1:0];
			rd_chk(a, 16'hA500 ^ (16'h0F0F * i[15:0]));
		end
		chk(timer_counter_value, 16'hA500);
		rd_chk(5'h1F, 16'h0000);
	endtask
	// Counter write refused while running, unbuffered period takes writes directly
	task automatic t_run_none;
		do_reset();
		wr_reg(OFS_CNT, 16'h0042);
		wr_reg(OFS_PER, 16'h1234);
		// A/D buffer holds a value so a stray transfer would show
		wr_reg(OFS_ADBA, 16'h0777);
		wr_reg(OFS_CTRL, 16'h2000);
		@(negedge clk);
		chk({15'h0000, running}, 16'h0001);
		wr_reg(OFS_CNT, 16'hFFFF);
		rd_chk(OFS_CNT, 16'h0042);
		// Mode change while running is refused and flagged
		wr_reg(OFS_CTRL, 16'h2010);
		rd_chk(OFS_CTRL, 16'h2000);
		rd_chk(OFS_STAT, 16'h0003);
		rd_chk(OFS_STAT, 16'h0001);
		wr_reg(OFS_PBUF, 16'h5555);
		pulse(2, 1'b1);
		rd_chk(OFS_PER, 16'h1234);
		pulse(0, 1'b0);
		pulse(1, 1'b0);
		rd_chk(OFS_ADA, 16'h0000);
	endtask
	// Single buffering of A, B, period; transfer at sawtooth wrap
	task automatic t_single;
		do_reset();
		wr_reg(OFS_CTRL, 16'h2015);
		wr_reg(OFS_CCBA, 16'h0A0A);
		wr_reg(OFS_CCBB, 16'h0B0B);
		wr_reg(OFS_PBUF, 16'h0C0C);
		pulse(0, 1'b0);
		rd_chk(OFS_PER, 16'h0000);
		pulse(2, 1'b1);
		rd_chk(OFS_CCA, 16'h0A0A);
		rd_chk(OFS_CCB, 16'h0B0B);
		rd_chk(OFS_PER, 16'h0C0C);
	endtask
	// Double buffering of the period in triangle mode; end of period at valley
	task automatic t_double;
		do_reset();
		wr_reg(OFS_CTRL, 16'h3020);
		wr_reg(OFS_PBUF, 16'h1111);
		wr_reg(OFS_PDBUF, 16'h2222);
		@(negedge clk);
		chk({15'h0000, triangle_mode}, 16'h0001);
		pulse(2, 1'b0);
		rd_chk(OFS_PER, 16'h0000);
		pulse(1, 1'b1);
		rd_chk(OFS_PER, 16'h1111);
		rd_chk(OFS_PBUF, 16'h2222);
	endtask
	// Every A/D transfer timing code in triangle and sawtooth modes
	task automatic t_adc;
		logic [DW-1:0] b;
		logic [DW-1:0] e;
		for (int t = 0; t < 8; t++)
		begin
			b = 16'h0700 + t[15:0];
			do_reset();
			wr_reg(OFS_CTRL, 16'h2000 | {3'b000, t[2], 4'h0, t[1:0], 6'h00});
			wr_reg(OFS_ADBA, b);
			pulse(0, 1'b0);
			e = (t[2] && t[0]) ? b : 16'h0000;
			rd_chk(OFS_ADA, e);
			pulse(1, t[2]);
			e = (t[2] && t[1]) ? b : e;
			rd_chk(OFS_ADA, e);
			pulse(2, ~t[2]);
			e = (!t[2] && t[1:0] != 2'b00) ? b : e;
			rd_chk(OFS_ADA, e);
		end
	endtask
	// A/D trigger B in double-buffer mode with transfer at both turning points
	task automatic t_adc_dbl;
		do_reset();
		wr_reg(OFS_CTRL, 16'h3B00);
		wr_reg(OFS_ADBB, 16'h00B1);
		wr_reg(OFS_ADDB, 16'h00B2);
		pulse(0, 1'b0);
		rd_chk(OFS_ADB, 16'h00B1);
		rd_chk(OFS_ADBB, 16'h00B2);
		pulse(1, 1'b1);
		rd_chk(OFS_ADB, 16'h00B2);
	endtask
	// Watchdog: the sequence needs well under 2000 cycles
	initial
	begin
		#400000;
		failures++;
		stop_test();
	end
	// Main sequence
	initial
	begin
		t_regs();
		t_run_none();
		t_single();
		t_double();
		t_adc();
		t_adc_dbl();
		stop_test();
	end
endmodule
